// ===== dv/keypad_display_control_checker.sv
// port assertions of the keypad display control
`timescale 1ns/1ps
module keypad_display_control_checker (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic key_mode_i,
   input wire logic key_confirm_i,
   input wire logic key_up_i,
   input wire logic key_down_i,
   input wire logic key_shift_i,
   input wire logic alarm_active_i,
   input wire logic value_long_i,
   input wire logic [15:0] param_value_i,
   input wire panel_pkg::mode_t mode_o,
   input wire logic sub_level_o,
   input wire logic [1:0] edit_digit_o,
   input wire logic [15:0] edit_value_o,
   input wire logic commit_o,
   input wire logic [15:0] commit_value_o,
   input wire panel_pkg::flash_t flash_o
);
   import panel_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // mode key at top level steps, wraps and leaves sub-levels
   a_mode_step: assert property (
      $rose(key_mode_i) && !sub_level_o && mode_o != mode_addfunc
      |=> mode_o == $past(mode_o) + 3'h1) else $error("mode did not step");
   a_mode_wrap: assert property (
      $rose(key_mode_i) && !sub_level_o && mode_o == mode_addfunc
      |=> mode_o == mode_status) else $error("mode did not wrap");
   a_mode_return: assert property (
      $rose(key_mode_i) && sub_level_o
      |=> !sub_level_o && $stable(mode_o)) else $error("mode key kept sub-level");
   // confirm enters the editor or commits it
   a_confirm_enter: assert property (
      $rose(key_confirm_i) && !key_mode_i && !sub_level_o
      |=> sub_level_o && edit_value_o == $past(param_value_i)) else $error("no entry");
   a_confirm_commit: assert property (
      $rose(key_confirm_i) && !key_mode_i && sub_level_o
      |=> commit_o && commit_value_o == $past(edit_value_o)) else $error("no commit");
   a_commit_single: assert property (
      commit_o |=> !commit_o) else $error("commit pulse too long");
   // shift of the edited digit, and increase on the leftmost digit (digit 0)
   a_shift_digit: assert property (
      $rose(key_shift_i) && sub_level_o && !value_long_i
      && !(key_mode_i | key_confirm_i | key_up_i | key_down_i)
      |=> edit_digit_o == $past(edit_digit_o) + 2'h1) else $error("shift wrong");
   a_up_digit: assert property (
      $rose(key_up_i) && sub_level_o && !value_long_i && edit_digit_o == 2'h0
      && !(key_mode_i | key_confirm_i)
      |=> edit_value_o[15:12] == ($past(edit_value_o[15:12]) == 4'h9 ? 4'h0
      : $past(edit_value_o[15:12]) + 4'h1)) else $error("increase wrong");
   // an active alarm owns the flash pattern
   a_alarm_flash: assert property (
      alarm_active_i |-> ##[0:2] flash_o == flash_alarm) else $error("alarm not flashing");
   c_wrap: cover property ($rose(key_mode_i) && mode_o == mode_addfunc);
   c_commit: cover property (commit_o);
   c_alarm: cover property (flash_o == flash_alarm);
endmodule
bind keypad_display_control keypad_display_control_checker chk_u (.clk_i, .reset_i,
   .key_mode_i, .key_confirm_i, .key_up_i, .key_down_i, .key_shift_i, .alarm_active_i,
   .value_long_i, .param_value_i, .mode_o, .sub_level_o, .edit_digit_o, .edit_value_o,
   .commit_o, .commit_value_o, .flash_o);

// ===== dv/keypad_display_control_tb.sv
// self-checking bench of the keypad display control
`timescale 1ns/1ps
module keypad_display_control_tb;
   import panel_pkg::*;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [2:0] key_sel = 3'h0;
   logic [4:0] keys;
   logic alarm = 1'b0, alarm_rst = 1'b0, chk = 1'b0, seq = 1'b0, rep = 1'b0, vlong = 1'b0;
   logic [39:0] value = 40'h1234567890;
   logic [15:0] pval = 16'h9012;
   logic sub, commit, tag, blank;
   logic [1:0] dig;
   logic [15:0] ev, cv, digits;
   logic [7:0] item;
   mode_t mode;
   seg_t seg;
   flash_t flash;
   int error_cnt = 0, n_tests = 0, cycles = 0;
   always #2.5 clk_i = ~clk_i;
   panel_operator op_u (.clk_i(clk_i), .key_sel_i(key_sel), .keys_o(keys));
   keypad_display_control #(.tick_div(4)) dut_u (.clk_i(clk_i), .reset_i(reset_i),
      .key_mode_i(keys[0]), .key_confirm_i(keys[1]), .key_up_i(keys[2]),
      .key_down_i(keys[3]), .key_shift_i(keys[4]), .alarm_active_i(alarm),
      .alarm_reset_i(alarm_rst), .check_start_i(chk), .sequence_test_enable_param_i(seq),
      .repower_needed_i(rep), .value_i(value), .value_long_i(vlong), .param_value_i(pval),
      .mode_o(mode), .sub_level_o(sub), .item_o(item), .edit_digit_o(dig), .edit_value_o(ev),
      .commit_o(commit), .commit_value_o(cv), .seg_o(seg), .seg_tag_o(tag),
      .digits_o(digits), .flash_o(flash), .blank_o(blank));
   task automatic check(input string what, input logic [39:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done();
      if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // one key press through the operator, then time for the display to settle
   task automatic press(input logic [2:0] k);
      @(posedge clk_i) key_sel <= k;
      @(posedge clk_i) key_sel <= 3'h0;
      cyc(6);
   endtask
   task automatic t_modes();
      press(3'h3);
      check("item up", item, 8'h01);
      repeat (2) press(3'h4);
      check("item wrap", item, 8'h0f);
      for (int i = 1; i <= 6; i++) begin
         press(3'h1);
         check("mode", mode, i % 6);
      end
   endtask
   // edit with digit wraps, then commit and leave the editor
   task automatic t_edit();
      int n = 0;
      logic [15:0] v = 16'h0;
      press(3'h2);
      check("editor", ev, pval);
      press(3'h3);
      check("up", ev, 16'h0012);
      press(3'h5);
      press(3'h4);
      check("down", ev, 16'h0912);
      repeat (3) press(3'h5);
      check("digit", dig, 2'h0);
      @(posedge clk_i) key_sel <= 3'h2;
      @(posedge clk_i) key_sel <= 3'h0;
      repeat (8) begin
         cyc(1);
         if (commit === 1'b1) {n, v} = {n + 1, cv};
      end
      check("commit count", n, 1);
      check("commit value", v, 16'h0912);
      press(3'h1);
      check("top", {sub, mode}, {1'b0, mode_status});
   endtask
   // shift walks tag and digit screens of a long value
   task automatic t_split();
      int j, p;
      @(posedge clk_i) vlong <= 1'b1;
      press(3'h2);
      p = seg * 2 + !tag;
      for (int i = 0; i < 6; i++) begin
         press(3'h5);
         j = seg * 2 + !tag;
         check("segment", j, (p + 1) % 6);
         if (tag === 1'b1) check("tag", digits[15:12], 4'ha + seg);
         else check("digits", digits & (seg == seg_upper ? 16'h00ff : 16'hffff),
            16'(value >> (16 * (2 - seg))));
         p = j;
      end
      press(3'h1);
      @(posedge clk_i) vlong <= 1'b0;
   endtask
   task automatic t_blank(input string what, input int exp);
      int n = 0;
      repeat (8000) begin
         cyc(1);
         n += (blank === 1'b1);
      end
      check(what, n, exp);
   endtask
   task automatic t_flash();
      @(posedge clk_i) alarm <= 1'b1;
      cyc(3);
      t_blank("alarm blank", 4000);
      @(posedge clk_i) alarm <= 1'b0;
      cyc(3);
      check("alarm held", flash, flash_alarm);
      @(posedge clk_i) alarm_rst <= 1'b1;
      @(posedge clk_i) chk <= 1'b1;
      @(posedge clk_i) {alarm_rst, chk} <= 2'b00;
      cyc(11980);
      check("check", flash, flash_check);
      cyc(40);
      check("check end", flash, flash_none);
      @(posedge clk_i) seq <= 1'b1;
      t_blank("seq blank", 1000);
      @(posedge clk_i) {seq, rep} <= 2'b01;
      cyc(3);
      check("repower", flash, flash_repower);
      t_blank("repower blank", 2000);
   endtask
   // cuts a hang short
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 80000) begin
         error_cnt++;
         test_done();
      end
   end
   initial begin
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      cyc(2);
      check("reset mode", mode, mode_status);
      t_modes();
      t_edit();
      t_split();
      t_flash();
      test_done();
   end
endmodule

// ===== dv/panel_operator.sv
// operator at the keypad: presses one key on request, holds it, then lets go
`timescale 1ns/1ps
module panel_operator (
   input wire logic clk_i,
   input wire logic [2:0] key_sel_i,
   output logic [4:0] keys_o
);
   logic [4:0] keys = 5'h00;
   logic [1:0] hold = 2'h0;
   // a held key is released long before the next request, so each press is a clean edge
   always @(posedge clk_i) begin
      if (key_sel_i != 3'h0) begin
         keys <= 5'h01 << (key_sel_i - 3'h1);
         hold <= 2'h2;
      end else if (hold != 2'h0) begin
         hold <= hold - 2'h1;
      end else begin
         keys <= 5'h00;
      end
   end
   assign keys_o = keys;
endmodule

// ===== src/key_pulse.sv
// turns one synchronous key level into a one-cycle press pulse
`timescale 1ns/1ps
module key_pulse (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic key_i,
   output logic press_o
);
   typedef struct packed {
      logic last;
   } key_state_t;
   key_state_t state;
   key_state_t next_state;

   // remember the previous level
   always_comb begin
      next_state = state;
      next_state.last = key_i;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // a press is the rising edge of the key
   assign press_o = key_i & ~state.last;
endmodule

// ===== src/keypad_display_control.sv
// front-panel keypad decoding, display mode stepping, flashing and value splitting
// Function
// - six display modes from status to additional
// - mode key advances mode, or leaves sub-level
// - confirm key enters next step or commits
// - increase key increments item or digit
// - decrease key decrements item or digit
// - shift key moves edited digit rightwards
// - alarm flashes at half second until reset
// - parameter check flashes three seconds, then stops
// - sequence test flashes once every two seconds
// - repower notice flashes twice every two seconds
// - long values split into upper, middle, lower
// - shift shows segment tag, then its digits
`timescale 1ns/1ps
module keypad_display_control #(
   parameter int unsigned tick_div = panel_pkg::tick_cycles,
   parameter int unsigned item_max = 15
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic key_mode_i,
   input wire logic key_confirm_i,
   input wire logic key_up_i,
   input wire logic key_down_i,
   input wire logic key_shift_i,
   input wire logic alarm_active_i,
   input wire logic alarm_reset_i,
   input wire logic check_start_i,
   input wire logic sequence_test_enable_param_i,
   input wire logic repower_needed_i,
   input wire logic [39:0] value_i,
   input wire logic value_long_i,
   input wire logic [15:0] param_value_i,
   output panel_pkg::mode_t mode_o,
   output logic sub_level_o,
   output logic [7:0] item_o,
   output logic [1:0] edit_digit_o,
   output logic [15:0] edit_value_o,
   output logic commit_o,
   output logic [15:0] commit_value_o,
   output panel_pkg::seg_t seg_o,
   output logic seg_tag_o,
   output logic [15:0] digits_o,
   output panel_pkg::flash_t flash_o,
   output logic blank_o
);
   import panel_pkg::*;

   // flash timing counted in millisecond ticks
   localparam int unsigned half_ticks = half_flash_ms / tick_ms;
   localparam int unsigned check_ticks = check_hold_ms / tick_ms;
   localparam int unsigned slow_ticks = slow_flash_ms / tick_ms;
   localparam int unsigned off_ticks = blink_off_ms / tick_ms;

   // whole block state, registered as one word
   typedef struct packed {
      mode_t mode;
      logic sub;
      logic [7:0] item;
      logic [1:0] digit;
      logic [15:0] edit;
      logic commit;
      logic [15:0] commit_value;
      seg_t seg;
      logic tag;
      logic alarm_latched;
      logic [15:0] check_left;
      logic [15:0] phase;
      logic blank;
      logic [15:0] digits;
   } panel_state_t;
   panel_state_t state;
   panel_state_t next_state;

   // key presses, timing enable and helpers of the next-state logic
   logic p_mode;
   logic p_confirm;
   logic p_up;
   logic p_down;
   logic p_shift;
   logic tick;
   logic [15:0] digit_step;
   logic [3:0] cur_digit;
   flash_t flash;
   logic [15:0] pick;
   seg_t seg_after;

   // one edge detector per key
   // keys arrive debounced, so a rising edge is one press
   key_pulse u_key_mode (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .key_i(key_mode_i),
      .press_o(p_mode)
   );
   key_pulse u_key_confirm (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .key_i(key_confirm_i),
      .press_o(p_confirm)
   );
   key_pulse u_key_up (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .key_i(key_up_i),
      .press_o(p_up)
   );
   key_pulse u_key_down (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .key_i(key_down_i),
      .press_o(p_down)
   );
   key_pulse u_key_shift (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .key_i(key_shift_i),
      .press_o(p_shift)
   );

   // millisecond enable for all flash timing
   ms_tick #(
      .cycles(tick_div)
   ) u_tick (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .tick_o(tick)
   );

   // weight of the edited hex digit, digit 0 is leftmost
   always_comb begin
      digit_step = 16'h1 << (4'(3 - state.digit) * 4);
      cur_digit = 4'(state.edit >> (4'(3 - state.digit) * 4));
   end

   // flash pattern by priority: alarm, check, sequence test, repower
   always_comb begin
      if (state.alarm_latched) begin
         flash = flash_alarm;
      end else if (state.check_left != 16'h0) begin
         flash = flash_check;
      end else if (sequence_test_enable_param_i) begin
         flash = flash_seq_test;
      end else if (repower_needed_i) begin
         flash = flash_repower;
      end else begin
         flash = flash_none;
      end
   end

   // piece of the long value for the current segment, decimal digit nibbles
   always_comb begin
      unique case (state.seg)
         seg_upper: pick = {digit_blank, digit_blank, value_i[39:32]};
         seg_middle: pick = value_i[31:16];
         seg_lower: pick = value_i[15:0];
         default: pick = {4{digit_blank}}; // unused segment code
      endcase
   end

   // segment that follows the current one, lower wraps to upper
   always_comb begin
      if (state.seg == seg_lower) begin
         seg_after = seg_upper;
      end else begin
         seg_after = seg_t'(2'(state.seg) + 2'h1);
      end
   end

   always_comb begin
      next_state = state;
      next_state.commit = 1'b0;

      // mode key: leave sub-level, else step mode with wrap
      if (p_mode) begin
         if (state.sub) begin
            next_state.sub = 1'b0;
         end else if (state.mode == mode_addfunc) begin
            next_state.mode = mode_status;
         end else begin
            next_state.mode = mode_t'(3'(state.mode) + 3'h1);
         end
         next_state.item = 8'h0;
         next_state.digit = 2'h0;
         next_state.seg = seg_upper;
         next_state.tag = 1'b0;
      end else if (p_confirm) begin
         // enter the item, or commit the edited value
         if (state.sub) begin
            next_state.commit = 1'b1;
            next_state.commit_value = state.edit;
         end else begin
            next_state.sub = 1'b1;
            next_state.edit = param_value_i;
            next_state.digit = 2'h0;
            next_state.seg = seg_upper;
            next_state.tag = 1'b0;
         end
      end else if (p_up) begin
         // no carry: an edited digit wraps within itself
         if (state.sub) begin
            next_state.edit = (cur_digit == 4'h9) ? state.edit - 16'(9) * digit_step
               : state.edit + digit_step;
         end else begin
            next_state.item = (state.item == 8'(item_max)) ? 8'h0 : state.item + 8'h1;
         end
      end else if (p_down) begin
         if (state.sub) begin
            next_state.edit = (cur_digit == 4'h0) ? state.edit + 16'(9) * digit_step
               : state.edit - digit_step;
         end else begin
            next_state.item = (state.item == 8'h0) ? 8'(item_max) : state.item - 8'h1;
         end
      end else if (p_shift && state.sub) begin
         if (value_long_i) begin
            // a press moves to the next segment's tag, the next press shows its digits
            if (!state.tag) begin
               next_state.tag = 1'b1;
               next_state.seg = seg_after;
            end else begin
               next_state.tag = 1'b0;
            end
         end else begin
            next_state.digit = state.digit + 2'h1;
         end
      end

      // alarm stays latched until alarm reset
      // set wins, so a reset during a live alarm changes nothing
      if (alarm_active_i) begin
         next_state.alarm_latched = 1'b1;
      end else if (alarm_reset_i) begin
         next_state.alarm_latched = 1'b0;
      end

      // check window and flash phase run on the millisecond tick
      // a new start reloads the full check window
      if (check_start_i) begin
         next_state.check_left = 16'(check_ticks);
      end else if (tick && state.check_left != 16'h0) begin
         next_state.check_left = state.check_left - 16'h1;
      end
      // phase sweeps one two second frame shared by every pattern
      if (tick) begin
         next_state.phase = (state.phase >= 16'(slow_ticks - 1)) ? 16'h0
            : state.phase + 16'h1;
      end

      // blanking per pattern within a two second frame
      unique case (flash)
         flash_alarm, flash_check: next_state.blank =
            (state.phase % 16'(half_ticks)) >= 16'(half_ticks / 2);
         flash_seq_test: next_state.blank = state.phase < 16'(off_ticks);
         flash_repower: next_state.blank = state.phase < 16'(off_ticks)
            || (state.phase >= 16'(2 * off_ticks) && state.phase < 16'(3 * off_ticks));
         default: next_state.blank = 1'b0;
      endcase

      // shown digits: tag, split piece, or plain value
      if (state.sub && value_long_i) begin
         if (state.tag) begin
            unique case (state.seg)
               seg_upper: next_state.digits = {tag_upper, {3{digit_blank}}};
               seg_middle: next_state.digits = {tag_middle, {3{digit_blank}}};
               seg_lower: next_state.digits = {tag_lower, {3{digit_blank}}};
               default: next_state.digits = {4{digit_blank}};
            endcase
         end else begin
            next_state.digits = pick;
         end
      end else if (state.sub) begin
         next_state.digits = state.edit;
      end else begin
         next_state.digits = {8'h0, state.item};
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // outputs
   assign mode_o = state.mode;
   assign sub_level_o = state.sub;
   assign item_o = state.item;
   assign edit_digit_o = state.digit;
   assign edit_value_o = state.edit;
   assign commit_o = state.commit;
   assign commit_value_o = state.commit_value;

   // display outputs, all from flip-flops except the flash code
   assign seg_o = state.seg;
   assign seg_tag_o = state.tag;
   assign digits_o = state.digits;
   assign flash_o = flash;
   assign blank_o = state.blank;
endmodule

// ===== src/ms_tick.sv
// divider that gives a one-cycle enable every millisecond
`timescale 1ns/1ps
module ms_tick #(
   parameter int unsigned cycles = panel_pkg::tick_cycles
) (
   input wire logic clk_i,
   input wire logic reset_i,
   output logic tick_o
);
   import panel_pkg::*;
   typedef struct packed {
      logic [31:0] count;
      logic tick;
   } tick_state_t;
   tick_state_t state;
   tick_state_t next_state;

   // count down one period and pulse at the end
   always_comb begin
      next_state = state;
      next_state.tick = 1'b0;
      if (state.count == 32'h0) begin
         next_state.count = 32'(cycles - 1);
         next_state.tick = 1'b1;
      end else begin
         next_state.count = state.count - 32'h1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign tick_o = state.tick;
endmodule

// ===== src/panel_pkg.sv
// shared constants and types of the front-panel keypad and display logic
package panel_pkg;
   // display modes, in mode-key order
   typedef enum logic [2:0] {
      mode_status,
      mode_monitor,
      mode_alarm,
      mode_param,
      mode_posdata,
      mode_addfunc
   } mode_t;
   localparam int unsigned mode_count = 6;
   // flash patterns: none, then the others highest priority first
   typedef enum logic [2:0] {
      flash_none,
      flash_alarm,
      flash_check,
      flash_seq_test,
      flash_repower
   } flash_t;
   // timing, as figures in ms, and clock rate
   localparam int unsigned clk_hz = 200_000_000;
   localparam int unsigned tick_ms = 1;
   localparam int unsigned tick_cycles = clk_hz / 1000 * tick_ms;
   localparam int unsigned half_flash_ms = 500;
   localparam int unsigned check_hold_ms = 3000;
   localparam int unsigned slow_flash_ms = 2000;
   localparam int unsigned blink_off_ms = 250;
   // value splitting: upper piece of two digits, middle and lower pieces of four digits
   localparam int unsigned digits_per_screen = 4;
   localparam int unsigned value_digits = 10;
   typedef enum logic [1:0] {
      seg_upper,
      seg_middle,
      seg_lower
   } seg_t;
   // blank digit code and segment indicator codes shown on the tag screen
   localparam logic [3:0] digit_blank = 4'hf;
   localparam logic [3:0] tag_upper = 4'ha;
   localparam logic [3:0] tag_middle = 4'hb;
   localparam logic [3:0] tag_lower = 4'hc;
endpackage
